// ==== rtl/sgoc_top.sv ====
// Switchgear output control: inputs 4..13, open/close, signal outputs
`include "sgoc_cfg.svh"
module sgoc_top #(
    parameter int unsigned TICK_CYC = `SGOC_TICK_CYC
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic [`SGOC_NCH-1:0] chan_in,
    input wire logic [`SGOC_NCH-1:0] input_polarity_sel,
    input wire logic [`SGOC_NCH*`SGOC_DLY_W-1:0] activation_delay,
    input wire logic [`SGOC_NCH*`SGOC_DLY_W-1:0] deactivation_delay,
    input wire logic [`SGOC_NCH*`SGOC_SEL_W-1:0] signal_target_sel,
    input wire logic [`SGOC_NCH*`SGOC_SEL_W-1:0] control_target_sel,
    input wire logic [`SGOC_NCH-1:0] control_inhibit_sel,
    input wire logic [`SGOC_NLED-1:0] indicator_latch_cfg,
    input wire logic indicator_reset,
    input wire logic energy_pulse_mode,
    input wire logic interlock_run_enable,
    input wire logic prog_step,
    input wire logic [`SGOC_LINE_W-1:0] prog_line,
    input wire logic prog_is_end,
    input wire sgoc_pkg::sgoc_code_t prog_code,
    input wire logic prog_value,
    input wire logic remote_key,
    input wire logic local_open_btn,
    input wire logic local_close_btn,
    input wire logic direct_cmd_valid,
    input wire logic direct_command,
    input wire logic arm_open,
    input wire logic arm_close,
    input wire logic execute_armed,
    input wire logic cancel_armed,
    input wire logic [`SGOC_PT_W-1:0] open_pulse_time,
    input wire logic [`SGOC_PT_W-1:0] close_pulse_time,
    input wire logic supervision_en,
    input wire logic supervision_alarm,
    input wire logic aux_power_ok,
    input wire logic internal_fault,
    output logic open_out,
    output logic close_out,
    output logic signal_out_one,
    output logic signal_out_two,
    output logic signal_out_three,
    output logic signal_out_four,
    output logic internal_fault_out,
    output logic [`SGOC_NLED-1:0] indicator_out,
    output logic [`SGOC_NCH-1:0] chan_active,
    output logic event_valid,
    output logic [3:0] event_chan,
    output logic event_state,
    output logic energy_pulse,
    output sgoc_pkg::sgoc_arm_e arm_state
);
    import sgoc_pkg::*;

    // ***********************************************
    // Output code decode
    // ***********************************************
    // Bits: 0 open, 1 close, 2 cond open, 3 cond close, 4..7 signals
    function automatic sgoc_hit_t oc_hit(input sgoc_code_t c);
        sgoc_hit_t h;
        h = 8'h00;
        if (c == `SGOC_OC_OPEN) h[0] = 1'h1;
        if (c == `SGOC_OC_CLOSE) h[1] = 1'h1;
        if (c == `SGOC_OC_COPEN) h[2] = 1'h1;
        if (c == `SGOC_OC_CCLOSE) h[3] = 1'h1;
        for (int k = 0; k < 4; k++) begin
            if (c == `SGOC_OC_SIG1 + 8'(k)) h[4+k] = 1'h1;
        end
        return h;
    endfunction

    // ***********************************************
    // Timebase
    // ***********************************************
    logic [21:0] tick_cnt_q;
    logic tick;
    assign tick = (tick_cnt_q == 22'(TICK_CYC - 1));
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) tick_cnt_q <= 22'h0;
        else if (tick) tick_cnt_q <= 22'h0;
        else tick_cnt_q <= tick_cnt_q + 22'h1;
    end

    // ***********************************************
    // Input channels
    // ***********************************************
    logic [`SGOC_NCH-1:0] act, chg, eff, chg_eff, rise;
    for (genvar g = 0; g < `SGOC_NCH; g++) begin : g_ch
        sgoc_chan u_ch (
            .ref_clk(ref_clk),
            .resetn(resetn),
            .pin_in(chan_in[g]),
            .polarity_high(input_polarity_sel[g]),
            .tick(tick),
            .act_dly(activation_delay[g*`SGOC_DLY_W +: `SGOC_DLY_W]),
            .deact_dly(deactivation_delay[g*`SGOC_DLY_W +: `SGOC_DLY_W]),
            .active(act[g]),
            .change(chg[g])
        );
    end
    // Counter channel is masked out of every other function
    always_comb begin
        eff = act;
        chg_eff = chg;
        if (energy_pulse_mode) begin
            eff[`SGOC_CH7] = 1'h0;
            chg_eff[`SGOC_CH7] = 1'h0;
        end
    end
    assign rise = chg_eff & eff;
    assign chan_active = eff;
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) energy_pulse <= 1'h0;
        else energy_pulse <= energy_pulse_mode && chg[`SGOC_CH7] && act[`SGOC_CH7];
    end

    // ***********************************************
    // Channel links to outputs
    // ***********************************************
    // Zero selectors decode to nothing, so reset leaves no links
    logic inh_open, inh_close, ch_open, ch_close;
    logic [3:0] ch_sig;
    always_comb begin
        sgoc_hit_t ct, st;
        ct = 8'h00;
        st = 8'h00;
        inh_open = 1'h0;
        inh_close = 1'h0;
        ch_open = 1'h0;
        ch_close = 1'h0;
        ch_sig = 4'h0;
        for (int i = 0; i < `SGOC_NCH; i++) begin
            ct = oc_hit(control_target_sel[i*`SGOC_SEL_W +: `SGOC_SEL_W]);
            st = oc_hit(signal_target_sel[i*`SGOC_SEL_W +: `SGOC_SEL_W]);
            if (control_inhibit_sel[i]) begin
                inh_open = inh_open | (eff[i] & ct[0]);
                inh_close = inh_close | (eff[i] & ct[1]);
            end else begin
                ch_open = ch_open | (rise[i] & ct[0]);
                ch_close = ch_close | (rise[i] & ct[1]);
            end
            ch_sig = ch_sig | ({4{eff[i]}} & st[7:4]);
        end
    end

    // ***********************************************
    // Program result capture
    // ***********************************************
    // Results of one scan are committed together at the shared END
    logic in_range;
    sgoc_hit_t ph, scan_q, res_q;
    assign in_range = prog_line >= `SGOC_LINE_FIRST && prog_line <= `SGOC_LINE_LAST;
    assign ph = oc_hit(prog_code);
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            scan_q <= 8'h00;
            res_q <= 8'h00;
        end else if (prog_step && in_range) begin
            if (prog_is_end) begin
                res_q <= scan_q;
                scan_q <= 8'h00;
            end else if (prog_value) begin
                scan_q <= scan_q | ph;
            end
        end
    end

    // ***********************************************
    // Interlock permission
    // ***********************************************
    logic permit_open, permit_close;
    assign permit_open = !interlock_run_enable || (res_q[0] && !inh_open);
    assign permit_close = !interlock_run_enable || (res_q[1] && !inh_close);

    // ***********************************************
    // Secured control
    // ***********************************************
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) arm_state <= ARM_IDLE;
        else if (execute_armed || cancel_armed) arm_state <= ARM_IDLE;
        else if (remote_key && arm_open) arm_state <= ARM_OPEN;
        else if (remote_key && arm_close) arm_state <= ARM_CLOSE;
    end

    // ***********************************************
    // Open and close requests
    // ***********************************************
    // Local buttons act only in local, serial commands only in remote
    logic open_req, close_req, open_start, close_start;
    logic open_busy, close_busy, dir_ok;
    assign dir_ok = remote_key && direct_cmd_valid;
    assign open_req = ch_open || (local_open_btn && !remote_key)
        || (dir_ok && direct_command == `SGOC_CMD_OPEN)
        || (remote_key && execute_armed && arm_state == ARM_OPEN);
    assign close_req = ch_close || (local_close_btn && !remote_key)
        || (dir_ok && direct_command != `SGOC_CMD_OPEN)
        || (remote_key && execute_armed && arm_state == ARM_CLOSE);
    assign open_start = open_req && permit_open;
    assign close_start = close_req && permit_close;

    sgoc_pulse u_open (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .start(open_start),
        .tick(tick),
        .len(open_pulse_time),
        .busy(open_busy)
    );
    sgoc_pulse u_close (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .start(close_start),
        .tick(tick),
        .len(close_pulse_time),
        .busy(close_busy)
    );

    // ***********************************************
    // Output drivers
    // ***********************************************
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            open_out <= 1'h0;
            close_out <= 1'h0;
        end else begin
            open_out <= open_busy || res_q[2];
            close_out <= close_busy || res_q[3];
        end
    end
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            signal_out_one <= 1'h0;
            signal_out_two <= 1'h0;
            signal_out_three <= 1'h0;
            signal_out_four <= 1'h0;
        end else begin
            signal_out_one <= ch_sig[0] || res_q[4];
            signal_out_two <= ch_sig[1] || res_q[5];
            signal_out_three <= ch_sig[2] || res_q[6];
            signal_out_four <= ch_sig[3] || res_q[7]
                || (supervision_en && supervision_alarm);
        end
    end
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) internal_fault_out <= 1'h0;
        else internal_fault_out <= aux_power_ok && !internal_fault;
    end

    // ***********************************************
    // Indicators for channels 4..9
    // ***********************************************
    // Two tick edges guarantee at least one full tick of activity
    logic [1:0] led_cnt_q [`SGOC_NLED];
    logic [`SGOC_NLED-1:0] mem_q;
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            mem_q <= '0;
            indicator_out <= '0;
            for (int i = 0; i < `SGOC_NLED; i++) led_cnt_q[i] <= 2'h0;
        end else begin
            for (int i = 0; i < `SGOC_NLED; i++) begin
                if (!eff[i]) led_cnt_q[i] <= 2'h0;
                else if (tick && led_cnt_q[i] != `SGOC_LATCH_TICKS)
                    led_cnt_q[i] <= led_cnt_q[i] + 2'h1;
                if (indicator_latch_cfg[i] && led_cnt_q[i] == `SGOC_LATCH_TICKS)
                    mem_q[i] <= 1'h1;
                else if (indicator_reset || !indicator_latch_cfg[i])
                    mem_q[i] <= 1'h0;
                indicator_out[i] <= eff[i] || mem_q[i];
            end
        end
    end

    // ***********************************************
    // Event reporting
    // ***********************************************
    // Pending flags keep simultaneous changes; a new change beats the clear
    logic [`SGOC_NCH-1:0] pend_q, pick;
    logic [3:0] pick_idx;
    always_comb begin
        pick = '0;
        pick_idx = 4'h0;
        for (int i = `SGOC_NCH - 1; i >= 0; i--) begin
            if (pend_q[i]) begin
                pick = '0;
                pick[i] = 1'h1;
                pick_idx = 4'(i);
            end
        end
    end
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            pend_q <= '0;
            event_valid <= 1'h0;
            event_chan <= 4'h0;
            event_state <= 1'h0;
        end else begin
            pend_q <= (pend_q & ~pick) | chg_eff;
            event_valid <= |pend_q;
            event_chan <= pick_idx + 4'h4;
            event_state <= eff[pick_idx];
        end
    end

    // ***********************************************
    // Checks
    // ***********************************************
    sequence s_exec_open;
        arm_state == ARM_OPEN && execute_armed && remote_key;
    endsequence
    sequence s_open_fires;
        permit_open && !open_busy;
    endsequence
    property p_bypass;
        @(posedge ref_clk) disable iff (!resetn)
        !interlock_run_enable |-> permit_open && permit_close;
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass blocked");
    property p_inhibit;
        @(posedge ref_clk) disable iff (!resetn)
        interlock_run_enable && inh_open |-> !open_start;
    endproperty
    a_inhibit: assert property (p_inhibit) else $error("inhibit ignored");
    property p_secured;
        @(posedge ref_clk) disable iff (!resetn)
        s_exec_open ##0 s_open_fires |=> open_busy ##1 open_out;
    endproperty
    a_secured: assert property (p_secured) else $error("execute lost");
    property p_disarm;
        @(posedge ref_clk) disable iff (!resetn)
        execute_armed || cancel_armed |=> arm_state == ARM_IDLE;
    endproperty
    a_disarm: assert property (p_disarm) else $error("still armed");
    property p_direct;
        @(posedge ref_clk) disable iff (!resetn)
        dir_ok && direct_command && permit_close && !close_busy |=> close_busy;
    endproperty
    a_direct: assert property (p_direct) else $error("direct lost");
    property p_gate;
        @(posedge ref_clk) disable iff (!resetn)
        $rose(open_busy) |-> $past(permit_open);
    endproperty
    a_gate: assert property (p_gate) else $error("ungated pulse");
    property p_event;
        @(posedge ref_clk) disable iff (!resetn)
        |chg_eff |-> ##2 event_valid;
    endproperty
    a_event: assert property (p_event) else $error("event lost");
    property p_counter;
        @(posedge ref_clk) disable iff (!resetn)
        energy_pulse_mode |-> !chan_active[`SGOC_CH7];
    endproperty
    a_counter: assert property (p_counter) else $error("counter used");
    property p_fault;
        @(posedge ref_clk) disable iff (!resetn)
        aux_power_ok && !internal_fault |=> internal_fault_out;
    endproperty
    a_fault: assert property (p_fault) else $error("fault output");
    property p_super;
        @(posedge ref_clk) disable iff (!resetn)
        supervision_en && supervision_alarm |=> signal_out_four;
    endproperty
    a_super: assert property (p_super) else $error("sig four");
    property p_level;
        @(posedge ref_clk) disable iff (!resetn)
        res_q[3] [*2] |=> close_out;
    endproperty
    a_level: assert property (p_level) else $error("cond level");
endmodule

// ==== rtl/sgoc_cfg.svh ====
// Constants for the switchgear output control block
//
// Contract
// - Decode 20/220 open, 21/221 close, 22..25 signal one to four
// - Conditional and interlock programs share line range and one END
// - Latched indicator of channels 4..9 holds after 10 ms activity
// - Each channel active high or low, high by default
// - Activation and deactivation delays in 20 ms steps up to 60 s (the code does not clamp settings above 3000 steps)
// - Every channel status change yields an event record
// - One channel drives one signal output and one control target
// - Channel control requests ignore the key but obey interlock
// - Signal output follows input; open/close pulses use set time
// - Inhibiting channel blocks open/close unless interlock disabled
// - Channel 7 as energy counter serves no other function
// - After reset channels have no link to outputs
// - Pushbutton, serial and channel requests pulse only when enabled
// - Pulse times 0.1 to 100 s in 0.1 s steps, 0.1 s default
// - Direct command 0 opens, 1 closes, if interlock allows
// - Secured control arms then executes; execute or cancel disarm
// - Conditional logic drives open/close as a level
// - Supervision also drives signal output four when enabled
// - Fault output set while powered and no internal fault
// - Interlock run disabled means open and close always enabled
`ifndef SGOC_CFG_SVH
`define SGOC_CFG_SVH
// ***********************************************
// Timing
// ***********************************************
`define SGOC_CLK_NS 4
`define SGOC_TICK_NS 10000000
`define SGOC_TICK_CYC (`SGOC_TICK_NS / `SGOC_CLK_NS)
`define SGOC_STEP_TICKS 2
`define SGOC_LATCH_TICKS 2'h2
`define SGOC_UNIT_TICKS 14'hA
`define SGOC_PT_MIN 10'h001
`define SGOC_PT_MAX 10'h3E8
`define SGOC_PT_DEF 10'h001
`define SGOC_DLY_MAX 12'hBB8
// ***********************************************
// Widths and codes
// ***********************************************
`define SGOC_NCH 10
`define SGOC_NLED 6
`define SGOC_CH7 3
`define SGOC_DLY_W 12
`define SGOC_SEL_W 8
`define SGOC_PT_W 10
`define SGOC_LINE_W 9
`define SGOC_LINE_FIRST 9'h0C8
`define SGOC_LINE_LAST 9'h12C
`define SGOC_OC_OPEN 8'h14
`define SGOC_OC_CLOSE 8'h15
`define SGOC_OC_SIG1 8'h16
`define SGOC_OC_COPEN 8'hDC
`define SGOC_OC_CCLOSE 8'hDD
`define SGOC_CMD_OPEN 1'h0
`endif

// ==== rtl/sgoc_pkg.sv ====
// Types for the switchgear output control block
package sgoc_pkg;
    typedef enum logic [2:0] {
        ARM_IDLE = 3'h1,
        ARM_OPEN = 3'h2,
        ARM_CLOSE = 3'h4
    } sgoc_arm_e;
    typedef logic [7:0] sgoc_code_t;
    typedef logic [7:0] sgoc_hit_t;
endpackage

// ==== rtl/sgoc_chan.sv ====
// One conditioned input channel: sync, polarity, delays
`include "sgoc_cfg.svh"
module sgoc_chan (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic pin_in,
    input wire logic polarity_high,
    input wire logic tick,
    input wire logic [`SGOC_DLY_W-1:0] act_dly,
    input wire logic [`SGOC_DLY_W-1:0] deact_dly,
    output logic active,
    output logic change
);
    logic s1_q, s2_q, s3_q, lvl_q, act_q, chg_q, want, go;
    logic [12:0] cnt_q, lim;
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            s1_q <= 1'h0;
            s2_q <= 1'h0;
            s3_q <= 1'h0;
            lvl_q <= 1'h0;
        end else begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) lvl_q <= s3_q;
        end
    end
    assign want = (lvl_q == polarity_high);
    assign lim = {(want ? act_dly : deact_dly), 1'h0};
    assign go = (want != act_q) && (cnt_q >= lim);
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            act_q <= 1'h0;
            chg_q <= 1'h0;
            cnt_q <= 13'h0;
        end else begin
            chg_q <= go;
            if (go) act_q <= want;
            if (go || want == act_q) cnt_q <= 13'h0;
            else if (tick) cnt_q <= cnt_q + 13'h1;
        end
    end
    assign active = act_q;
    assign change = chg_q;
endmodule

// ==== rtl/sgoc_pulse.sv ====
// Timed control pulse in 0.1 s units
`include "sgoc_cfg.svh"
module sgoc_pulse (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic start,
    input wire logic tick,
    input wire logic [`SGOC_PT_W-1:0] len,
    output logic busy
);
    logic busy_q;
    logic [13:0] cnt_q;
    logic [`SGOC_PT_W-1:0] len_c;
    // Out-of-range settings are clamped rather than rejected
    always_comb begin
        len_c = len;
        if (len < `SGOC_PT_MIN) len_c = `SGOC_PT_MIN;
        if (len > `SGOC_PT_MAX) len_c = `SGOC_PT_MAX;
    end
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            busy_q <= 1'h0;
            cnt_q <= 14'h0;
        end else if (start && !busy_q) begin
            busy_q <= 1'h1;
            cnt_q <= 14'(len_c) * `SGOC_UNIT_TICKS;
        end else if (busy_q && tick) begin
            if (cnt_q <= 14'h1) busy_q <= 1'h0;
            cnt_q <= cnt_q - 14'h1;
        end
    end
    assign busy = busy_q;
endmodule

// ==== tb/sgoc_gear.sv ====
// Switchgear model: counts open and close pulses and times the last open pulse
module sgoc_gear (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic open_out,
    input wire logic close_out,
    output int opens,
    output int closes,
    output int open_len
);
    timeunit 1ns;
    timeprecision 1ps;
    int run_q;
    logic open_q;
    logic close_q;
    // ***********************************************
    // Coil model
    // ***********************************************
    // Counts rising edges only, so a pulse that is held longer still counts once
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            opens <= 0;
            closes <= 0;
            open_len <= 0;
            run_q <= 0;
            open_q <= 1'b0;
            close_q <= 1'b0;
        end else begin
            open_q <= open_out;
            close_q <= close_out;
            if (open_out && !open_q) opens <= opens + 1;
            if (close_out && !close_q) closes <= closes + 1;
            run_q <= open_out ? run_q + 1 : 0;
            if (!open_out && open_q) open_len <= run_q;
        end
    end
endmodule

// ==== tb/sgoc_top_bench.sv ====
// Self-checking bench for the switchgear output control block
module sgoc_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk, resetn, run_en, key, cmd, end_f, pm, sup_en, sup_al, aux, flt;
    logic [9:0] cin, pol, inh;
    logic [7:0] st;
    logic [119:0] adly, ddly;
    logic [9:0] opt, cpt;
    logic [8:0] pline;
    logic [7:0] pcode;
    logic [5:0] lcfg;
    logic oo, co, s1, s2, s3, s4, ifo, evv, evs, enp;
    logic [5:0] ind;
    logic [9:0] act;
    logic [3:0] evc, ev_c;
    logic ev_s;
    sgoc_pkg::sgoc_arm_e arm;
    int err_total, checked, evn, enn, cyc, opens, closes, olen, ev0;
    sgoc_top #(.TICK_CYC(10)) u_sgoc_top (.ref_clk(ref_clk), .resetn(resetn), .chan_in(cin),
        .input_polarity_sel(pol), .activation_delay(adly), .deactivation_delay(ddly),
        .signal_target_sel({72'h0, 8'h16}), .control_target_sel({56'h0, 8'h14, 16'h0014}),
        .control_inhibit_sel(inh), .indicator_latch_cfg(lcfg), .indicator_reset(st[5]),
        .energy_pulse_mode(pm), .interlock_run_enable(run_en), .prog_step(st[6]),
        .prog_line(pline), .prog_is_end(end_f), .prog_code(pcode), .prog_value(1'b1),
        .remote_key(key), .local_open_btn(st[7]), .local_close_btn(1'b0),
        .direct_cmd_valid(st[0]), .direct_command(cmd), .arm_open(st[1]), .arm_close(st[2]),
        .execute_armed(st[3]), .cancel_armed(st[4]), .open_pulse_time(opt),
        .close_pulse_time(cpt), .supervision_en(sup_en), .supervision_alarm(sup_al),
        .aux_power_ok(aux), .internal_fault(flt), .open_out(oo), .close_out(co),
        .signal_out_one(s1), .signal_out_two(s2), .signal_out_three(s3), .signal_out_four(s4),
        .internal_fault_out(ifo), .indicator_out(ind), .chan_active(act), .event_valid(evv),
        .event_chan(evc), .event_state(evs), .energy_pulse(enp), .arm_state(arm));
    sgoc_gear u_sgoc_gear (.ref_clk(ref_clk), .resetn(resetn), .open_out(oo), .close_out(co),
        .opens(opens), .closes(closes), .open_len(olen));
    // ***********************************************
    // Clock, monitor and timeout
    // ***********************************************
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cyc++;
        if (evv === 1'b1) begin
            evn++;
            ev_c <= evc;
            ev_s <= evs;
        end
        if (enp === 1'b1) enn++;
        if (cyc > 6000) begin
            err_total++;
            final_report();
        end
    end
    // ***********************************************
    // Tasks
    // ***********************************************
    task automatic w(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    // One-cycle strobe: 0 direct, 1/2 arm, 3 execute, 4 cancel, 5 indicator reset
    task automatic go(input int k);
        st[k] = 1'b1;
        w(1);
        st[k] = 1'b0;
        w(1);
    endtask
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        checked++;
        if (g !== e) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // ***********************************************
    // Tests
    // ***********************************************
    initial begin
        {resetn, run_en, key, cmd, end_f, pm, sup_en, sup_al, flt} = '0;
        {cin, inh, st, adly, ddly, cpt} = '0;
        {pline, pcode, opt} = {9'h0C8, 8'h14, 10'h001};
        aux = 1'b1;
        pol = 10'h3FF;
        lcfg = 6'h01;
        repeat (12) @(negedge ref_clk);
        resetn = 1'b1;
        w(3);
        chk("arm", 16'h1, arm);
        chk("ifo", 16'h1, ifo);
        flt = 1'b1;
        w(3);
        chk("ifo", 16'h0, ifo);
        flt = 1'b0;
        $display("test reset done");
        run_en = 1'b1;
        key = 1'b1;
        go(0);
        w(130);
        chk("opens", 16'h0, 16'(opens));
        go(6);
        pcode = 8'h18;
        go(6);
        {end_f, pline} = {1'b1, 9'h12C};
        go(6);
        end_f = 1'b0;
        go(0);
        w(4);
        chk("open", 16'h1, oo);
        chk("sig3", 16'h1, s3);
        chk("sig2", 16'h0, s2);
        w(130);
        chk("opens", 16'h1, 16'(opens));
        chk("len", 16'h1, 16'(olen >= 90 && olen <= 111));
        run_en = 1'b0;
        cmd = 1'b1;
        go(0);
        w(130);
        chk("closes", 16'h1, 16'(closes));
        $display("test direct done");
        go(1);
        w(2);
        chk("arm", 16'h2, arm);
        go(3);
        w(2);
        chk("arm", 16'h1, arm);
        go(2);
        w(2);
        chk("arm", 16'h4, arm);
        go(4);
        w(130);
        chk("arm", 16'h1, arm);
        chk("opens", 16'h2, 16'(opens));
        chk("closes", 16'h1, 16'(closes));
        key = 1'b0;
        go(7);
        w(130);
        chk("opens", 16'h3, 16'(opens));
        $display("test secured done");
        cin[0] = 1'b1;
        w(8);
        chk("sig1", 16'h1, s1);
        chk("evc", 16'h14, {3'h0, ev_s, ev_c});
        w(130);
        chk("opens", 16'h4, 16'(opens));
        chk("open", 16'h0, oo);
        chk("sig1", 16'h1, s1);
        cin[0] = 1'b0;
        w(8);
        chk("sig1", 16'h0, s1);
        chk("ind", 16'h1, ind[0]);
        go(5);
        w(3);
        chk("ind", 16'h0, ind[0]);
        {adly[11:0], ddly[11:0]} = {12'h001, 12'h001};
        cin[0] = 1'b1;
        w(12);
        chk("act", 16'h0, act[0]);
        w(30);
        chk("act", 16'h1, act[0]);
        cin[0] = 1'b0;
        w(12);
        chk("act", 16'h1, act[0]);
        {adly, ddly} = '0;
        pol[1] = 1'b0;
        w(130);
        chk("act", 16'h1, act[1]);
        pol[1] = 1'b1;
        $display("test channel done");
        run_en = 1'b1;
        inh[2] = 1'b1;
        cin[2] = 1'b1;
        key = 1'b1;
        cmd = 1'b0;
        w(8);
        go(0);
        w(130);
        chk("opens", 16'h5, 16'(opens));
        run_en = 1'b0;
        opt = 10'h002;
        go(0);
        w(230);
        chk("opens", 16'h6, 16'(opens));
        chk("len", 16'h1, 16'(olen >= 190 && olen <= 211));
        cin[2] = 1'b0;
        {sup_en, sup_al} = 2'h3;
        w(3);
        chk("sig4", 16'h1, s4);
        pm = 1'b1;
        w(8);
        ev0 = evn;
        cin[3] = 1'b1;
        w(8);
        chk("events", 16'(ev0), 16'(evn));
        chk("epulse", 16'h1, 16'(enn > 0));
        chk("evc", 16'h6, {12'h0, ev_c});
        pcode = 8'hDD;
        go(6);
        end_f = 1'b1;
        go(6);
        end_f = 1'b0;
        w(30);
        chk("close", 16'h1, co);
        $display("test misc done");
        final_report();
    end
endmodule
